// file: design/vfv_top.sv
// Field and vertical blanking bit generator with its registers
//
// The register offsets and the strobed register port were chosen for this implementation.
module vfv_top
  import vfv_pkg::*;
(
  input  wire  logic                        clock,            // Pixel clock, 40 MHz
  input  wire  logic                        rst,              // Async reset, high
  input  wire  logic [vfv_pkg::VFV_ADDR_W-1:0] reg_addr,      // Register byte address
  input  wire  logic [31:0]                 reg_wdata,        // Write data
  input  wire  logic                        reg_wr,           // Write strobe
  input  wire  logic                        reg_rd,           // Read strobe
  output logic [31:0]                       reg_rdata,        // Read data, next cycle
  input  wire  logic                        raw_mode,         // Raw data display mode
  input  wire  logic                        eav_strobe,       // EAV opening a line
  input  wire  logic                        sav_strobe,       // SAV of current line
  input  wire  logic [11:0]                 frame_line_count, // Frame line counter
  output logic                              eav_f_bit,        // F for EAV code
  output logic                              eav_v_bit,        // V for EAV code
  output logic                              sav_f_bit,        // F for SAV code
  output logic                              sav_v_bit,        // V for SAV code
  output logic                              dma_request_enable // Field 1 DMA events allowed
);

  import vfv_pkg::*;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [31:0] field_bit_lines_ff;
  logic [31:0] field1_vblank_bit_lines_ff;
  logic [31:0] field2_vblank_bit_lines_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_field_bit_lines;
  logic [31:0] nxt_field1_vblank_bit_lines;
  logic [31:0] nxt_field2_vblank_bit_lines;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_field_bit_lines         = field_bit_lines_ff;
    nxt_field1_vblank_bit_lines = field1_vblank_bit_lines_ff;
    nxt_field2_vblank_bit_lines = field2_vblank_bit_lines_ff;
    nxt_rdata                   = 32'h00000000;
    if (reg_wr) begin
      case (reg_addr)
        VFV_ADDR_FIELD_BIT: begin
          nxt_field_bit_lines = reg_wdata & VFV_WRITE_MASK;
        end
        VFV_ADDR_F1_VBLANK: begin
          nxt_field1_vblank_bit_lines = reg_wdata & VFV_WRITE_MASK;
        end
        VFV_ADDR_F2_VBLANK: begin
          nxt_field2_vblank_bit_lines = reg_wdata & VFV_WRITE_MASK;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        VFV_ADDR_FIELD_BIT: nxt_rdata = field_bit_lines_ff;
        VFV_ADDR_F1_VBLANK: nxt_rdata = field1_vblank_bit_lines_ff;
        VFV_ADDR_F2_VBLANK: nxt_rdata = field2_vblank_bit_lines_ff;
        default:            nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      field_bit_lines_ff         <= VFV_REG_RESET;
      field1_vblank_bit_lines_ff <= VFV_REG_RESET;
      field2_vblank_bit_lines_ff <= VFV_REG_RESET;
      rdata_ff                   <= 32'h00000000;
    end else begin
      field_bit_lines_ff         <= nxt_field_bit_lines;
      field1_vblank_bit_lines_ff <= nxt_field1_vblank_bit_lines;
      field2_vblank_bit_lines_ff <= nxt_field2_vblank_bit_lines;
      rdata_ff                   <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************************
  // Line fields
  // ****************************************************
  logic [11:0] field2_start_line;
  logic [11:0] field1_start_line;
  logic [11:0] f1_vblank_start_line;
  logic [11:0] f1_active_start_line;
  logic [11:0] f2_vblank_start_line;
  logic [11:0] f2_active_start_line;

  assign field2_start_line    = field_bit_lines_ff[VFV_HI_MSB:VFV_HI_LSB];
  assign field1_start_line    = field_bit_lines_ff[VFV_LO_MSB:VFV_LO_LSB];
  assign f1_active_start_line = field1_vblank_bit_lines_ff[VFV_HI_MSB:VFV_HI_LSB];
  assign f1_vblank_start_line = field1_vblank_bit_lines_ff[VFV_LO_MSB:VFV_LO_LSB];
  assign f2_active_start_line = field2_vblank_bit_lines_ff[VFV_HI_MSB:VFV_HI_LSB];
  assign f2_vblank_start_line = field2_vblank_bit_lines_ff[VFV_LO_MSB:VFV_LO_LSB];

  // ****************************************************
  // Bit generation
  // ****************************************************
  logic eav_active;
  logic f_q;
  logic v1_q;
  logic v2_q;

  // Raw mode uses no timing codes, so the bits freeze
  assign eav_active = eav_strobe & ~raw_mode;

  // Only line count compares drive F, no external field signal
  vfv_line_match u_field_bit (
    .clock      (clock),
    .rst        (rst),
    .eav_strobe (eav_active),
    .line_count (frame_line_count),
    .set_line   (field2_start_line),
    .clr_line   (field1_start_line),
    .bit_q      (f_q)
  );

  vfv_line_match u_f1_vblank (
    .clock      (clock),
    .rst        (rst),
    .eav_strobe (eav_active),
    .line_count (frame_line_count),
    .set_line   (f1_vblank_start_line),
    .clr_line   (f1_active_start_line),
    .bit_q      (v1_q)
  );

  vfv_line_match u_f2_vblank (
    .clock      (clock),
    .rst        (rst),
    .eav_strobe (eav_active),
    .line_count (frame_line_count),
    .set_line   (f2_vblank_start_line),
    .clr_line   (f2_active_start_line),
    .bit_q      (v2_q)
  );

  assign eav_f_bit = f_q;
  assign eav_v_bit = v1_q | v2_q;

  // ****************************************************
  // SAV copies
  // ****************************************************
  logic sav_f_ff;
  logic sav_v_ff;
  logic nxt_sav_f;
  logic nxt_sav_v;

  always_comb begin
    nxt_sav_f = sav_f_ff;
    nxt_sav_v = sav_v_ff;
    if (sav_strobe & ~raw_mode) begin
      nxt_sav_f = f_q;
      nxt_sav_v = v1_q | v2_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sav_f_ff <= 1'b0;
      sav_v_ff <= 1'b0;
    end else begin
      sav_f_ff <= nxt_sav_f;
      sav_v_ff <= nxt_sav_v;
    end
  end

  assign sav_f_bit = sav_f_ff;
  assign sav_v_bit = sav_v_ff;

  // ****************************************************
  // Field 1 DMA gating
  // ****************************************************
  vfv_dma_state_t dma_state_ff;
  vfv_dma_state_t nxt_dma_state;

  always_comb begin
    nxt_dma_state = dma_state_ff;
    case (dma_state_ff)
      VFV_WAIT_LINE1: begin
        if (frame_line_count == VFV_DMA_START_LINE) begin
          nxt_dma_state = VFV_DMA_RUN;
        end
      end
      VFV_DMA_RUN: begin
        nxt_dma_state = VFV_DMA_RUN;
      end
      default: begin
        nxt_dma_state = VFV_WAIT_LINE1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dma_state_ff <= VFV_WAIT_LINE1;
    end else begin
      dma_state_ff <= nxt_dma_state;
    end
  end

  assign dma_request_enable = (dma_state_ff == VFV_DMA_RUN);

endmodule

// file: shared/vfv_pkg.sv
// Package for the display field and vertical bit generator
//
// Notes on behaviour
// - Clear line match at EAV drives F to 0
// - F holds until set line, then 1
// - F ignores the external field output
// - Field register: set 27-16, clear 11-0
// - Reserved bits read zero, ignore writes
// - Field 1 vblank start match sets V
// - V holds until field 1 active line
// - V ignores the external vblank output
// - Field 1 DMA requests start at line 1
// - Field 1 V register: clear 27-16, set 11-0
// - Field 2 vblank start match sets V
// - V holds until field 2 active line
// - Field 2 V register: clear 27-16, set 11-0
package vfv_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [3:0] VFV_ADDR_FIELD_BIT   = 4'h0;
  localparam logic [3:0] VFV_ADDR_F1_VBLANK   = 4'h4;
  localparam logic [3:0] VFV_ADDR_F2_VBLANK   = 4'h8;
  localparam int         VFV_ADDR_W           = 4;

  // ****************************************************
  // Field layout
  // ****************************************************
  localparam int          VFV_LINE_W          = 12;
  localparam int          VFV_HI_LSB          = 16;
  localparam int          VFV_HI_MSB          = 27;
  localparam int          VFV_LO_LSB          = 0;
  localparam int          VFV_LO_MSB          = 11;
  localparam logic [31:0] VFV_WRITE_MASK      = 32'h0FFF0FFF;
  localparam logic [31:0] VFV_REG_RESET       = 32'h00000000;
  localparam logic [11:0] VFV_DMA_START_LINE  = 12'h001;

  typedef enum logic [1:0] {
    VFV_WAIT_LINE1,
    VFV_DMA_RUN
  } vfv_dma_state_t;

endpackage

// file: design/vfv_line_match.sv
// Set and clear comparator holding one timing reference bit
module vfv_line_match (
  input  wire  logic        clock,      // Pixel clock
  input  wire  logic        rst,        // Async reset, high
  input  wire  logic        eav_strobe, // EAV opening a line
  input  wire  logic [11:0] line_count, // Frame line count
  input  wire  logic [11:0] set_line,   // Line that sets the bit
  input  wire  logic [11:0] clr_line,   // Line that clears the bit
  output logic              bit_q       // Held bit value
);

  logic bit_ff;
  logic nxt_bit;

  always_comb begin
    nxt_bit = bit_ff;
    if (eav_strobe) begin
      if (line_count == clr_line) begin
        nxt_bit = 1'b0;
      end else if (line_count == set_line) begin
        nxt_bit = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
    end
  end

  assign bit_q = bit_ff;

endmodule

// file: bench/vfv_chk.sv
// Checker for the field and vertical bit generator ports
module vfv_chk (
  input wire logic        clock,              // Clock
  input wire logic        rst,                // Reset
  input wire logic        reg_rd,             // Read strobe
  input wire logic [31:0] reg_rdata,          // Read data
  input wire logic        raw_mode,           // Raw mode
  input wire logic        eav_strobe,         // EAV strobe
  input wire logic        sav_strobe,         // SAV strobe
  input wire logic [11:0] frame_line_count,   // Line count
  input wire logic        eav_f_bit,          // EAV F
  input wire logic        eav_v_bit,          // EAV V
  input wire logic        sav_f_bit,          // SAV F
  input wire logic        sav_v_bit,          // SAV V
  input wire logic        dma_request_enable  // DMA gate
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  rd_mask_a: assert property (reg_rd |=> (reg_rdata & 32'hF000F000) == 32'h0)
    else $error("reserved read bits set");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  eav_hold_a: assert property (!eav_strobe |=> $stable({eav_f_bit, eav_v_bit}))
    else $error("EAV bits moved without EAV");
  sav_hold_a: assert property (!sav_strobe |=> $stable({sav_f_bit, sav_v_bit}))
    else $error("SAV bits moved without SAV");
  sav_copy_a: assert property (sav_strobe && !raw_mode |=>
    {sav_f_bit, sav_v_bit} == $past({eav_f_bit, eav_v_bit}))
    else $error("SAV bits differ from EAV bits");
  raw_freeze_a: assert property (raw_mode |=>
    $stable({eav_f_bit, eav_v_bit, sav_f_bit, sav_v_bit}))
    else $error("bits moved in raw mode");
  dma_keep_a: assert property (dma_request_enable |=> dma_request_enable)
    else $error("DMA gate dropped");
  dma_start_a: assert property (frame_line_count == 12'h001 |=> dma_request_enable)
    else $error("DMA gate not opened at line one");
  dma_wait_a: assert property (!dma_request_enable && frame_line_count != 12'h001
    |=> !dma_request_enable)
    else $error("DMA gate opened early");

  field2_c: cover property (eav_strobe && frame_line_count == 12'h11B);
  raw_c: cover property (raw_mode && eav_strobe);
  dma_c: cover property ($rose(dma_request_enable));
endmodule

bind vfv_top vfv_chk u_chk (
  .clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .raw_mode(raw_mode), .eav_strobe(eav_strobe), .sav_strobe(sav_strobe),
  .frame_line_count(frame_line_count), .eav_f_bit(eav_f_bit), .eav_v_bit(eav_v_bit),
  .sav_f_bit(sav_f_bit), .sav_v_bit(sav_v_bit), .dma_request_enable(dma_request_enable)
);

// file: bench/vfv_enc_model.sv
// Encoder model that picks up the F and V bits from SAV codes
module vfv_enc_model (
  input  wire logic clock,      // Clock
  input  wire logic rst,        // Reset
  input  wire logic sav_strobe, // SAV strobe
  input  wire logic sav_f_bit,  // SAV F
  input  wire logic sav_v_bit,  // SAV V
  output logic      rx_f,       // Received F
  output logic      rx_v        // Received V
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sav_d;
  // Code is taken one cycle after the SAV strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sav_d <= 1'b0;
      rx_f  <= 1'b0;
      rx_v  <= 1'b0;
    end else begin
      sav_d <= sav_strobe;
      if (sav_d) begin
        rx_f <= sav_f_bit;
        rx_v <= sav_v_bit;
      end
    end
  end
endmodule

// file: bench/vfv_top_tb_top.sv
// Testbench for the field and vertical bit generator
module vfv_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vfv_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
  logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, raw_mode = 0;
  logic        eav_strobe = 0, sav_strobe = 0, f, v1, v2;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [11:0] frame_line_count = 12'h000;
  logic        eav_f_bit, eav_v_bit, sav_f_bit, sav_v_bit, dma_request_enable, rx_f, rx_v;
  int          num_errors = 0, comparisons = 0, cycles = 0;

  always #12.5 clock = ~clock;

  vfv_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_mode(raw_mode),
    .eav_strobe(eav_strobe), .sav_strobe(sav_strobe), .frame_line_count(frame_line_count),
    .eav_f_bit(eav_f_bit), .eav_v_bit(eav_v_bit), .sav_f_bit(sav_f_bit),
    .sav_v_bit(sav_v_bit), .dma_request_enable(dma_request_enable));
  vfv_enc_model u_enc (.clock(clock), .rst(rst), .sav_strobe(sav_strobe),
    .sav_f_bit(sav_f_bit), .sav_v_bit(sav_v_bit), .rx_f(rx_f), .rx_v(rx_v));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // One line: EAV, then SAV, then the encoder picks up the code
  task automatic line(input int n, input logic ef, input logic ev);
    @(posedge clock);
    frame_line_count <= n[11:0];
    eav_strobe       <= 1'b1;
    @(posedge clock);
    eav_strobe <= 1'b0;
    sav_strobe <= 1'b1;
    @(posedge clock);
    sav_strobe <= 1'b0;
    @(posedge clock);
    #1 `CHK({eav_f_bit, eav_v_bit, rx_f, rx_v}, {ef, ev, ef, ev})
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(4'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(4'(4 * i), 32'hFFFFFFFF);
      rd(4'(4 * i), (i == 3) ? 32'h0 : 32'h0FFF0FFF);
    end
    $display("test registers done");
    wr(VFV_ADDR_FIELD_BIT, 32'h011B0014);
    wr(VFV_ADDR_F1_VBLANK, 32'h00140001);
    wr(VFV_ADDR_F2_VBLANK, 32'h011B0108);
    rd(VFV_ADDR_F1_VBLANK, 32'h00140001);
    `CHK(dma_request_enable, 1'b0)
    f  = 1'b0;
    v1 = 1'b0;
    v2 = 1'b0;
    for (int n = 0; n < 300; n++) begin
      if (n == 20) f = 1'b0;
      else if (n == 283) f = 1'b1;
      if (n == 20) v1 = 1'b0;
      else if (n == 1) v1 = 1'b1;
      if (n == 283) v2 = 1'b0;
      else if (n == 264) v2 = 1'b1;
      line(n, f, v1 | v2);
      if (n == 0) `CHK(dma_request_enable, 1'b0)
    end
    `CHK(dma_request_enable, 1'b1)
    $display("test lines done");
    @(posedge clock);
    raw_mode <= 1'b1;
    line(20, 1'b1, 1'b0);
    @(posedge clock);
    raw_mode <= 1'b0;
    line(20, 1'b0, 1'b0);
    $display("test raw mode done");
    wr(VFV_ADDR_FIELD_BIT, 32'h0FFF0014);
    wr(VFV_ADDR_F2_VBLANK, 32'h0FFF0FFE);
    for (int n = 0; n < 300; n++) begin
      if (n == 20) v1 = 1'b0;
      else if (n == 1) v1 = 1'b1;
      line(n, 1'b0, v1);
    end
    $display("test progressive done");
    end_of_test();
  end
endmodule
